// ### core/cic_consts.svh
// Constants for the completion interrupt coalescer.
// Assumes a 200 MHz clock and limits sampled at reset release.
// Overview of operation
// - Hold time limit 0 to 63 ms
// - Time limit zero disables coalescing; default zero
// - Response batch limit 1 to 255
// - Count reached raises one covering interrupt
// - Batch limit below two: interrupt per response
// - Batch limit defaults to eight
// - Coalescing: interrupt at time or count first
// - Coalescing off: one interrupt per completion
// - New limits apply only after reset
`ifndef CIC_CONSTS_SVH
`define CIC_CONSTS_SVH
`define CIC_CLK_MHZ 200
`define CIC_MS_NS 1000000
`define CIC_CLK_NS 5
`define CIC_MS_CYCLES (`CIC_MS_NS / `CIC_CLK_NS)
`define CIC_TIME_W 6
`define CIC_COUNT_W 8
`define CIC_TIME_RST 6'h00
`define CIC_COUNT_RST 8'h08
`define CIC_BATCH_MIN 8'h02
`endif

// ### core/cic_pkg.sv
// Types for the completion interrupt coalescer.
// Assumes the constants header is included by users.
package cic_pkg;
  typedef enum logic [1:0] {CIC_IDLE, CIC_PENDING} cic_state_type;
endpackage

// ### core/cic_ms_tick.sv
// Millisecond tick divider.
// Assumes one clock and a synchronous active-low reset.
`include "cic_consts.svh"
module cic_ms_tick
  import cic_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `CIC_MS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic restart,
  output logic tick
);
  logic [31:0] cnt_r;

  // Count cycles; restart aligns the first ms to the first pending response
  always_ff @(posedge clock) begin
    if (!rst_n || restart) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_r == 32'(MS_CYCLES - 1)) begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ### core/cic_coalescer.sv
// Completion interrupt coalescer top.
// Assumes completion pulses and limits come from logic on the same clock.
`include "cic_consts.svh"
module cic_coalescer
  import cic_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `CIC_MS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Configured limits, sampled at reset
  input wire logic [`CIC_TIME_W-1:0] hold_time_limit_ms,
  input wire logic [`CIC_COUNT_W-1:0] response_batch_limit,
  input wire logic limits_valid,
  // Completion stream
  input wire logic completion,
  // Host interrupt
  output logic irq,
  output logic [`CIC_COUNT_W-1:0] irq_count,
  output logic coalescing_on
);
  logic [`CIC_TIME_W-1:0] time_lim_r;
  logic [`CIC_COUNT_W-1:0] count_lim_r;
  logic [`CIC_COUNT_W-1:0] pend_r;
  logic [`CIC_COUNT_W-1:0] pend_nxt;
  logic [`CIC_TIME_W-1:0] ms_r;
  cic_state_type state_r;
  logic ms_tick;
  logic first_rsp;
  logic fire;
  logic in_reset_r;
  logic count_mode;
  // Check-only tallies
  logic [31:0] acc_r;
  logic [31:0] rep_r;
  logic [31:0] age_r;
  logic [31:0] age_lim;

  // Limits latched only while in reset or on its release cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      in_reset_r <= 1'b1;
      time_lim_r <= `CIC_TIME_RST;
      count_lim_r <= `CIC_COUNT_RST;
      coalescing_on <= (`CIC_TIME_RST != 6'h00);
    end else if (in_reset_r) begin
      in_reset_r <= 1'b0;
      if (limits_valid) begin
        time_lim_r <= hold_time_limit_ms;
        coalescing_on <= (hold_time_limit_ms != 6'h00);
        count_lim_r <= (response_batch_limit == 8'h00) ? 8'h01 : response_batch_limit;
      end
    end
  end

  // Mode decode and the next pending count
  assign count_mode = (count_lim_r >= `CIC_BATCH_MIN);
  assign first_rsp = completion && (state_r == CIC_IDLE);
  assign pend_nxt = (completion && pend_r != 8'hFF) ? pend_r + 8'h01 : pend_r;

  // Fire decision: per completion when not coalescing or batch limit below two, else time or count, whichever first
  always_comb begin
    fire = 1'b0;
    if (in_reset_r) begin
      fire = 1'b0;
    end else if (!coalescing_on || !count_mode) begin
      fire = completion;
    end else if (pend_nxt >= count_lim_r && pend_nxt != 8'h00) begin
      fire = 1'b1;
    end else if (state_r == CIC_PENDING && ms_tick && ms_r + 6'h01 >= time_lim_r) begin
      fire = 1'b1;
    end
  end

  cic_ms_tick #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .restart(first_rsp || fire),
    .tick(ms_tick)
  );

  // Pending state, count and elapsed ms
  always_ff @(posedge clock) begin
    if (!rst_n || in_reset_r) begin
      state_r <= CIC_IDLE;
      pend_r <= 8'h00;
      ms_r <= 6'h00;
    end else if (fire) begin
      state_r <= CIC_IDLE;
      pend_r <= 8'h00;
      ms_r <= 6'h00;
    end else begin
      pend_r <= pend_nxt;
      case (state_r)
        CIC_IDLE: begin
          if (completion) begin
            state_r <= CIC_PENDING;
            ms_r <= 6'h00;
          end
        end
        CIC_PENDING: begin
          if (ms_tick) begin
            ms_r <= ms_r + 6'h01;
          end
        end
        default: begin
          state_r <= CIC_IDLE;
        end
      endcase
    end
  end

  // Interrupt pulse and number of responses covered
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
      irq_count <= 8'h00;
    end else begin
      irq <= fire;
      irq_count <= fire ? pend_nxt : irq_count;
    end
  end

  // Shadow tallies of accepted and reported responses, used by checks only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_r <= 32'h0;
      rep_r <= 32'h0;
    end else begin
      if (completion && !in_reset_r) begin
        acc_r <= acc_r + 32'h1;
      end
      if (irq) begin
        rep_r <= rep_r + 32'(irq_count);
      end
    end
  end

  // Age of the oldest unreported response, in cycles
  always_ff @(posedge clock) begin
    if (!rst_n || pend_r == 8'h00) begin
      age_r <= 32'h0;
    end else begin
      age_r <= age_r + 32'h1;
    end
  end

  // Longest hold: limit in clock cycles plus the cycle that fires
  assign age_lim = 32'(32'(time_lim_r) * MS_CYCLES + 32'h1);

  // Every accepted response is pending, just reported, or already reported
  AST_CONSERVE: assert property (@(posedge clock) disable iff (!rst_n)
    acc_r == rep_r + 32'(pend_r) + (irq ? 32'(irq_count) : 32'h0))
    else $error("Responses lost or counted twice");

  // No response waits longer than the hold time
  AST_AGE: assert property (@(posedge clock) disable iff (!rst_n)
    age_r <= age_lim)
    else $error("Response held past the time limit");

  // A timed interrupt comes exactly at the limit after the first response
  AST_TIME_EXACT: assert property (@(posedge clock) disable iff (!rst_n)
    (coalescing_on && count_mode && irq && irq_count < count_lim_r) |-> age_r == age_lim)
    else $error("Timed interrupt off the first response start");

  // Limits taken from the inputs on the release cycle
  AST_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
    (in_reset_r && limits_valid) |=> time_lim_r == $past(hold_time_limit_ms) &&
      ($past(response_batch_limit) == 8'h00 || count_lim_r == $past(response_batch_limit)))
    else $error("Limits not taken at reset release");

  // Without valid limits the defaults stay
  AST_KEEP_DEFAULT: assert property (@(posedge clock) disable iff (!rst_n)
    (in_reset_r && !limits_valid) |=> time_lim_r == `CIC_TIME_RST &&
      count_lim_r == `CIC_COUNT_RST)
    else $error("Defaults lost without valid limits");

  // An interrupt always covers at least one response
  AST_NO_EMPTY: assert property (@(posedge clock) disable iff (!rst_n)
    irq |-> irq_count != 8'h00)
    else $error("Interrupt with no responses");

  // The release cycle neither interrupts nor counts
  AST_IGNORE_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
    in_reset_r |=> !irq && pend_r == 8'h00)
    else $error("Activity on the reset release cycle");

  // Checks on the interrupt path, the pending state and the limits
  AST_OFF_EACH: assert property (@(posedge clock) disable iff (!rst_n)
    (!coalescing_on && !in_reset_r && completion) |=> irq && irq_count == 8'h01)
    else $error("No interrupt for completion with coalescing off");
  AST_SINGLE: assert property (@(posedge clock) disable iff (!rst_n)
    (!count_mode && !in_reset_r && completion) |=> irq)
    else $error("Batch limit below two did not interrupt");
  AST_COUNT: assert property (@(posedge clock) disable iff (!rst_n)
    (irq && coalescing_on && count_mode) |-> irq_count <= count_lim_r)
    else $error("Interrupt covered more than the limit");
  AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    (coalescing_on && count_mode && irq) |-> irq_count >= count_lim_r || $past(ms_tick))
    else $error("Interrupt raised early");
  AST_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    irq |-> pend_r == 8'h00 && ms_r == 6'h00)
    else $error("Counters not cleared on interrupt");
  AST_START: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == CIC_IDLE && completion && !fire && !in_reset_r) |=> state_r == CIC_PENDING)
    else $error("Timer did not start");
  AST_STABLE: assert property (@(posedge clock) disable iff (!rst_n)
    !in_reset_r && !$past(in_reset_r) |-> $stable(time_lim_r) && $stable(count_lim_r))
    else $error("Limits changed outside reset");
  AST_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
    !in_reset_r |-> count_lim_r != 8'h00)
    else $error("Batch limit zero");
  AST_TIMEOUT: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == CIC_PENDING && coalescing_on) |-> ms_r < time_lim_r)
    else $error("Hold time exceeded");
  AST_DEFAULT: assert property (@(posedge clock)
    (!rst_n) |=> time_lim_r == 6'h00 && count_lim_r == 8'h08)
    else $error("Wrong reset defaults");

  COV_OFF: cover property (@(posedge clock) !coalescing_on && irq);
  COV_BY_COUNT: cover property (@(posedge clock) coalescing_on && irq && irq_count == count_lim_r);
  COV_BY_TIME: cover property (@(posedge clock) coalescing_on && irq && irq_count < count_lim_r);
  COV_SINGLE: cover property (@(posedge clock) coalescing_on && !count_mode && irq);
  COV_JOIN: cover property (@(posedge clock)
    coalescing_on && count_mode && completion && fire);
endmodule

// ### tb/cic_host_model.sv
// Host model: tallies interrupts and the responses they cover.
// Assumes irq is a one-cycle pulse on the rising edge.
`include "cic_consts.svh"
module cic_host_model (
  // Clock
  input wire logic clock,
  // Interrupt in
  input wire logic irq,
  input wire logic [`CIC_COUNT_W-1:0] irq_count,
  // Tallies
  output logic [31:0] irq_total,
  output logic [31:0] resp_total
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] irq_tot_r = 32'h0;
  logic [31:0] resp_tot_r = 32'h0;
  // Each interrupt serviced once
  always @(posedge clock) begin
    if (irq === 1'b1) begin
      irq_tot_r <= irq_tot_r + 32'h1;
      resp_tot_r <= resp_tot_r + 32'(irq_count);
    end
  end
  // Tallies out
  assign irq_total = irq_tot_r;
  assign resp_total = resp_tot_r;
endmodule

// ### tb/tb_cic_coalescer.sv
// Testbench for the completion interrupt coalescer.
// Assumes a 5 ns clock and a 20-cycle millisecond.
`include "cic_consts.svh"
module tb_cic_coalescer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MS = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [`CIC_TIME_W-1:0] t_lim = 6'h00;
  logic [`CIC_COUNT_W-1:0] b_lim = 8'h00;
  logic l_vld = 1'b0;
  logic completion = 1'b0;
  logic irq;
  logic [`CIC_COUNT_W-1:0] irq_count;
  logic coalescing_on;
  logic [31:0] irq_total;
  logic [31:0] resp_total;
  logic [31:0] di;
  logic [31:0] dr;
  int err_count = 0;
  int comparisons = 0;
  // Clock of 200 MHz
  always #2.5 clock = ~clock;
  cic_coalescer #(.MS_CYCLES(MS)) i_dut (.clock(clock), .rst_n(rst_n),
    .hold_time_limit_ms(t_lim), .response_batch_limit(b_lim), .limits_valid(l_vld),
    .completion(completion), .irq(irq), .irq_count(irq_count),
    .coalescing_on(coalescing_on));
  cic_host_model i_host (.clock(clock), .irq(irq), .irq_count(irq_count),
    .irq_total(irq_total), .resp_total(resp_total));
  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Counts, verdict, end of run
  task automatic summarize;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Reset for 12 cycles with given limits
  task automatic start(input logic [5:0] t, input logic [7:0] b, input logic v);
    rst_n = 1'b0;
    t_lim = t;
    b_lim = b;
    l_vld = v;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
  endtask
  // Back-to-back completions, then a quiet wait; deltas of the tallies
  task automatic burst(input int n, input int w);
    logic [31:0] i0;
    logic [31:0] r0;
    i0 = irq_total;
    r0 = resp_total;
    repeat (n) begin
      completion = 1'b1;
      @(negedge clock);
    end
    completion = 1'b0;
    repeat (w) @(negedge clock);
    di = irq_total - i0;
    dr = resp_total - r0;
  endtask
  // Defaults: no coalescing, one interrupt each
  task automatic s_default;
    start(6'h00, 8'h00, 1'b0);
    check({31'h0, coalescing_on}, 32'h0);
    burst(5, 4);
    check(di, 32'h5);
  endtask
  // Count limit 3, then limits changed without reset
  task automatic s_count;
    start(6'h0A, 8'h03, 1'b1);
    check({31'h0, coalescing_on}, 32'h1);
    burst(7, 3);
    check(di, 32'h2);
    check(dr, 32'h6);
    t_lim = 6'h00;
    b_lim = 8'h01;
    burst(2, 3);
    check(di, 32'h1);
    check(dr, 32'h3);
  endtask
  // Time limit 2 ms fires before count 8
  task automatic s_time;
    start(6'h02, 8'h08, 1'b1);
    burst(1, 2 * MS - 5);
    check(di, 32'h0);
    burst(0, 10);
    check(dr, 32'h1);
    check(di, 32'h1);
  endtask
  // Batch limit 1: one interrupt per response
  task automatic s_single;
    start(6'h05, 8'h01, 1'b1);
    burst(4, 3);
    check(di, 32'h4);
  endtask
  // Batch limit zero is taken as one
  task automatic s_zero;
    start(6'h03, 8'h00, 1'b1);
    check({31'h0, coalescing_on}, 32'h1);
    burst(3, 3);
    check(di, 32'h3);
    check(dr, 32'h3);
  endtask
  // Main sequence, inputs on falling edge
  initial begin
    @(negedge clock);
    s_default;
    s_count;
    s_time;
    s_single;
    s_zero;
    summarize;
  end
  // Watchdog
  initial begin
    #20000;
    err_count++;
    summarize;
  end
endmodule
